// File: bench/chain_readout_asserts.sv
/* Port checker for chain_readout.
   Assumes one-cycle answers to bus beats. */
`timescale 1ns/1ns
module chain_readout_asserts
    import chain_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic i_vme_valid,
    input wire logic [31:0] i_vme_addr,
    input wire logic [5:0] i_vme_am,
    input wire logic i_vme_write,
    input wire logic i_vme_addr_phase,
    input wire logic o_vme_dtack,
    input wire logic o_vme_berr,
    input wire logic [63:0] o_vme_rdata
);
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence rd_beat;
        i_vme_valid && !i_vme_write && !i_vme_addr_phase;
    endsequence
    sequence trailer_sent;
        o_vme_dtack && o_vme_rdata[TYPE_MSB:TYPE_LSB] == TYPE_TRAILER;
    endsequence
    reg_quiet_a: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
        else $error("stray read data");
    ack_cause_a: assert property (o_vme_dtack |-> $past(i_vme_valid))
        else $error("stray dtack");
    berr_cause_a: assert property (o_vme_berr |-> $past(i_vme_valid && !i_vme_write))
        else $error("stray berr");
    one_answer_a: assert property (!(o_vme_dtack && o_vme_berr))
        else $error("dtack with berr");
    modifier_a: assert property (rd_beat ##0 (i_vme_am != AM_BLOCK32 && i_vme_am != AM_BLOCK64)
        |=> !o_vme_dtack && !o_vme_berr) else $error("bad modifier answered");
    store_only_a: assert property (rd_beat ##0 (i_vme_addr[23:0] > STORE_WINDOW_TOP)
        |=> !o_vme_dtack && !o_vme_berr) else $error("read outside store answered");
    write_quiet_a: assert property (i_vme_valid && i_vme_write |=> o_vme_rdata == 64'h0 && !o_vme_berr)
        else $error("write gave data");
    trailer_last_a: assert property (trailer_sent |=> !o_vme_dtack)
        else $error("data after trailer");
endmodule // chain_readout_asserts

bind chain_readout chain_readout_asserts u_chain_readout_asserts (.i_clk, .i_rst_n, .i_reg_rd, .o_reg_rdata,
    .i_vme_valid, .i_vme_addr, .i_vme_am, .i_vme_write, .i_vme_addr_phase, .o_vme_dtack, .o_vme_berr, .o_vme_rdata);

// File: bench/crate_master.sv
/* Crate master model: one bus beat per call, write data always zero.
   Assumes the board answers one cycle after the beat. */
`timescale 1ns/1ns
module crate_master (
    input wire logic i_clk,
    output logic o_valid,
    output logic [31:0] o_addr,
    output logic [5:0] o_am,
    output logic o_write,
    output logic o_addr_phase,
    output logic [31:0] o_wdata
);
    initial {o_valid, o_addr, o_am, o_write, o_addr_phase, o_wdata} = '0;
    task automatic beat(input logic [31:0] a, input logic [5:0] am, input logic w, input logic ph);
        @(posedge i_clk);
        {o_valid, o_addr, o_am, o_write, o_addr_phase} <= {1'b1, a, am, w, ph};
        @(posedge i_clk);
        o_valid <= 1'b0;
        // The released address shows its inverse, so a stale address is never read as live.
        o_addr <= ~a;
    endtask
endmodule // crate_master

// File: bench/tb.sv
/* Bench for chain_readout: register tasks, beats through crate_master, one board.
   Assumes a 4 ns clock. */
`timescale 1ns/1ns
module tb;
    import chain_pkg::*;
    localparam logic [31:0] BASE = 32'hA500_0000;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_vme_berr_seen = 1'b0;
    logic i_iack_in = 1'b0, i_evt_valid = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0, i_evt_word = 32'h0, o_reg_rdata, i_vme_addr, i_vme_wdata;
    logic i_vme_valid, i_vme_write, i_vme_addr_phase, o_vme_dtack, o_vme_berr, o_iack_out, o_evt_ready, o_irq;
    logic [5:0] i_vme_am;
    logic [63:0] o_vme_rdata;
    logic [31:0] ev [3] = '{32'h0200_0001, 32'h0000_0ABC, 32'h0400_0001};
    int n_errors = 0, tests_run = 0;
    always #2 i_clk = ~i_clk;
    chain_readout #(.DEPTH_LOG(4)) u_chain_readout (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .i_vme_valid, .i_vme_addr, .i_vme_am, .i_vme_write, .i_vme_addr_phase,
        .i_vme_wdata, .i_vme_berr_seen, .o_vme_dtack, .o_vme_berr, .o_vme_rdata, .i_iack_in, .o_iack_out,
        .i_evt_valid, .i_evt_word, .o_evt_ready, .o_irq);
    crate_master u_crate_master (.i_clk, .o_valid(i_vme_valid), .o_addr(i_vme_addr), .o_am(i_vme_am),
        .o_write(i_vme_write), .o_addr_phase(i_vme_addr_phase), .o_wdata(i_vme_wdata));
    task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge i_clk);
        {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk(nm, o_reg_rdata, exp);
    endtask
    task automatic cb(input string nm, input logic [31:0] a, input logic [5:0] am, input logic w,
        input logic ph, input logic [65:0] exp);
        u_crate_master.beat(a, am, w, ph);
        #1;
        chk(nm, {o_vme_dtack, o_vme_berr, o_vme_rdata}, exp);
    endtask
    task automatic load;
        foreach (ev[i]) begin
            @(posedge i_clk);
            {i_evt_valid, i_evt_word} <= {1'b1, ev[i]};
        end
        @(posedge i_clk);
        i_evt_valid <= 1'b0;
        step();
    endtask
    task automatic rearm;
        @(posedge i_clk);
        i_vme_berr_seen <= 1'b1;
        @(posedge i_clk);
        i_vme_berr_seen <= 1'b0;
        step();
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(REG_CHAIN_ADDR, 32'h0, "chain addr reset");
        rd(REG_CONTROL, 32'h1, "advance reset");
        rd(8'h40, 32'h0, "unmapped read");
        wr(REG_CHAIN_ADDR, 32'hA5);
        wr(REG_CHAIN_CTRL, 32'h1);
        rd(REG_CHAIN_ADDR, 32'hA5, "chain addr");
        chk("store ready", o_evt_ready, 1'b1);
        $display("test registers done");
        load();
        cb("wrong modifier", BASE, 6'h09, 1'b0, 1'b0, '0);
        cb("other upper byte", 32'hA600_0000, AM_BLOCK32, 1'b0, 1'b0, '0);
        cb("register window read", BASE + 32'h1008, AM_BLOCK32, 1'b0, 1'b0, '0);
        cb("store write", BASE, AM_BLOCK32, 1'b1, 1'b0, '0);
        foreach (ev[i]) cb("head beat", BASE, AM_BLOCK32, 1'b0, 1'b0, {2'b10, 32'h0, ev[i]});
        step();
        chk("token out", o_iack_out, 1'b1);
        cb("drained head", BASE, AM_BLOCK32, 1'b0, 1'b0, '0);
        $display("test head readout done");
        rd(REG_IRQ_STATUS, 32'h1, "drained event");
        // A set mask bit enables its status bit onto the interrupt line.
        wr(REG_IRQ_MASK, 32'h0);
        step();
        chk("irq masked", o_irq, 1'b0);
        wr(REG_IRQ_MASK, 32'h7);
        step();
        chk("irq raised", o_irq, 1'b1);
        wr(REG_IRQ_STATUS, 32'h1);
        step();
        chk("irq cleared", o_irq, 1'b0);
        rearm();
        chk("empty head passes", o_iack_out, 1'b1);
        $display("test interrupt done");
        cb("multicast", BASE + 32'h1008, AM_BLOCK32, 1'b1, 1'b0, {2'b10, 64'h0});
        rd(REG_CONTROL, 32'h0, "multicast control");
        load();
        cb("header only", BASE, AM_BLOCK32, 1'b0, 1'b0, {2'b10, 32'h0, ev[0]});
        cb("no advance", BASE, AM_BLOCK32, 1'b0, 1'b0, '0);
        $display("test multicast done");
        rearm();
        wr(REG_CONTROL, 32'h1);
        wr(REG_CHAIN_CTRL, 32'h2);
        i_iack_in <= 1'b1;
        cb("address cycle", BASE, AM_BLOCK64, 1'b0, 1'b1, {2'b10, 64'h0});
        cb("tail header", BASE, AM_BLOCK64, 1'b0, 1'b0, {2'b10, 32'h0, ev[0]});
        rd(REG_CHAIN_ADDR, 32'hA5, "pause");
        for (int i = 1; i < 3; i++) cb("resume", BASE, AM_BLOCK64, 1'b0, 1'b0, {2'b10, 32'h0, ev[i]});
        cb("chain end", BASE, AM_BLOCK64, 1'b0, 1'b0, {2'b01, 64'h0});
        chk("tail keeps token", o_iack_out, 1'b0);
        cb("empty tail", BASE, AM_BLOCK32, 1'b0, 1'b0, {2'b01, 64'h0});
        rd(REG_STATUS, 32'h7, "tail status");
        rd(REG_IRQ_STATUS, 32'h3, "chain done event");
        $display("test tail done");
        conclude();
    end
endmodule // tb

// File: hdl/chain_pkg.sv
/*
 * Constants shared by the chained readout and multicast slave: register
 * offsets, field positions, reset values, address modifiers and word types.
 * Assumes a single 250 MHz clock and a synchronous view of the bus pins.
 */
package chain_pkg;
    localparam logic [7:0] REG_CHAIN_ADDR = 8'h00;
    localparam logic [7:0] REG_CHAIN_CTRL = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;

    localparam int CTRL_HEAD_BIT = 0;
    localparam int CTRL_TAIL_BIT = 1;
    localparam int CONTROL_ADVANCE_BIT = 0;
    localparam int STATUS_DRAINED_BIT = 0;
    localparam int STATUS_TOKEN_BIT = 1;
    localparam int STATUS_EMPTY_BIT = 2;
    localparam int STATUS_FULL_BIT = 3;
    localparam int IRQ_DRAINED_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_OVERRUN_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    localparam logic [7:0] CHAIN_ADDR_RESET = 8'h00;
    localparam logic [1:0] CHAIN_CTRL_RESET = 2'h0;
    localparam logic CONTROL_ADVANCE_RESET = 1'b1;

    localparam logic [5:0] AM_BLOCK32 = 6'h0F;
    localparam logic [5:0] AM_BLOCK64 = 6'h08;

    localparam logic [23:0] STORE_WINDOW_TOP = 24'h000FFF;
    localparam logic [23:0] REG_WINDOW_BASE = 24'h001000;
    localparam logic [23:0] REG_WINDOW_TOP = 24'h0010FF;

    localparam int TYPE_MSB = 26;
    localparam int TYPE_LSB = 24;
    localparam logic [2:0] TYPE_HEADER = 3'h2;
    localparam logic [2:0] TYPE_TRAILER = 3'h4;

    typedef enum logic [1:0] {
        ROLE_HEAD,
        ROLE_MIDDLE,
        ROLE_TAIL
    } chain_role_t;
endpackage

// File: hdl/chain_readout.sv
/*
 * Slave logic of one board in a chained block readout and multicast crate.
 * Holds the event store, the chain registers, the token logic and the
 * interrupt status. Assumes bus pins already synchronous to i_clk, one bus
 * data cycle per i_vme_valid pulse, and an upstream token level on i_iack_in.
 */
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
module chain_readout
    import chain_pkg::*;
#(
    parameter int DEPTH_LOG = 11
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_vme_valid,
    input wire logic [31:0] i_vme_addr,
    input wire logic [5:0] i_vme_am,
    input wire logic i_vme_write,
    input wire logic i_vme_addr_phase,
    input wire logic [31:0] i_vme_wdata,
    input wire logic i_vme_berr_seen,
    output logic o_vme_dtack,
    output logic o_vme_berr,
    output logic [63:0] o_vme_rdata,
    input wire logic i_iack_in,
    output logic o_iack_out,
    input wire logic i_evt_valid,
    input wire logic [31:0] i_evt_word,
    output logic o_evt_ready,
    output logic o_irq
);
    logic [7:0] chain_addr;
    logic head_flag;
    logic tail_flag;
    logic auto_advance_enable;
    logic drained;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [31:0] next_reg_rdata;
    logic [31:0] trailer_word;
    logic store_empty;
    logic store_full;
    logic store_ready;

    function automatic chain_role_t role_of(input logic head, input logic tail);
        if (head && !tail) begin
            return ROLE_HEAD;
        end else if (tail && !head) begin
            return ROLE_TAIL;
        end else begin
            return ROLE_MIDDLE;
        end
    endfunction

    function automatic logic in_range(input logic [23:0] off, input logic [23:0] lo, input logic [23:0] hi);
        return (off >= lo) && (off <= hi);
    endfunction

    wire chain_role_t role = role_of(head_flag, tail_flag);
    wire is_tail = role == ROLE_TAIL;
    wire [7:0] vme_upper = i_vme_addr[31:24];
    wire [23:0] vme_low = i_vme_addr[23:0];
    wire base_match = vme_upper == chain_addr;
    wire am_block = (i_vme_am == AM_BLOCK32) || (i_vme_am == AM_BLOCK64);
    wire am_wide = i_vme_am == AM_BLOCK64;
    wire chain_read = i_vme_valid && !i_vme_write && base_match && am_block &&
                      in_range(vme_low, 24'h000000, STORE_WINDOW_TOP);
    wire mcast_write = i_vme_valid && i_vme_write && base_match &&
                       in_range(vme_low, REG_WINDOW_BASE, REG_WINDOW_TOP);
    wire [7:0] mcast_offset = vme_low[7:0];

    wire token = (role == ROLE_HEAD) || i_iack_in;
    wire spent = drained || store_empty;
    wire sending = chain_read && token && !spent;
    wire addr_ack = sending && am_wide && i_vme_addr_phase;
    wire data_beat = sending && !(am_wide && i_vme_addr_phase);
    wire [2:0] word_type = trailer_word[TYPE_MSB:TYPE_LSB];
    wire beat_trailer = data_beat && (word_type == TYPE_TRAILER);
    wire beat_header_stop = data_beat && !auto_advance_enable && (word_type == TYPE_HEADER);
    wire store_pop = data_beat && auto_advance_enable;
    wire chain_done = chain_read && token && spent && is_tail;
    wire set_drained = beat_trailer || beat_header_stop || (chain_read && token && store_empty);

    // Local and multicast writes share one register file, except the chain address, which only the local port writes; local port wins a tie.
    wire local_wr = i_reg_wr;
    wire any_wr = local_wr || mcast_write;
    wire [7:0] wr_offset = local_wr ? i_reg_addr : mcast_offset;
    wire [31:0] wr_data = local_wr ? i_reg_wdata : i_vme_wdata;
    wire wr_chain_addr = local_wr && (i_reg_addr == REG_CHAIN_ADDR);
    wire wr_chain_ctrl = any_wr && (wr_offset == REG_CHAIN_CTRL);
    wire wr_control = any_wr && (wr_offset == REG_CONTROL);
    wire wr_irq_status = any_wr && (wr_offset == REG_IRQ_STATUS);
    wire wr_irq_mask = any_wr && (wr_offset == REG_IRQ_MASK);

    wire [IRQ_WIDTH-1:0] irq_events = {!store_ready && i_evt_valid, chain_done, set_drained && !drained};
    wire [IRQ_WIDTH-1:0] irq_clear = wr_irq_status ? wr_data[IRQ_WIDTH-1:0] : '0;
    // Set is applied after clear so an event in the clearing cycle survives.
    wire [IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

    wire [31:0] status_word = {28'h0000000, store_full, store_empty, token, drained};

    always_comb begin
        next_reg_rdata = 32'h00000000;
        if (i_reg_addr == REG_CHAIN_ADDR) begin
            next_reg_rdata = {24'h000000, chain_addr};
        end else if (i_reg_addr == REG_CHAIN_CTRL) begin
            next_reg_rdata = {30'h00000000, tail_flag, head_flag};
        end else if (i_reg_addr == REG_CONTROL) begin
            next_reg_rdata = {31'h00000000, auto_advance_enable};
        end else if (i_reg_addr == REG_STATUS) begin
            next_reg_rdata = status_word;
        end else if (i_reg_addr == REG_IRQ_STATUS) begin
            next_reg_rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_status};
        end else if (i_reg_addr == REG_IRQ_MASK) begin
            next_reg_rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_mask};
        end
    end

    event_store #(
        .WIDTH(32),
        .DEPTH_LOG(DEPTH_LOG)
    ) u_store (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr_valid(i_evt_valid),
        .i_wr_word(i_evt_word),
        .o_wr_ready(store_ready),
        .i_pop(store_pop),
        .o_word(trailer_word),
        .o_empty(store_empty),
        .o_full(store_full)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_addr <= CHAIN_ADDR_RESET;
            head_flag <= CHAIN_CTRL_RESET[CTRL_HEAD_BIT];
            tail_flag <= CHAIN_CTRL_RESET[CTRL_TAIL_BIT];
            auto_advance_enable <= CONTROL_ADVANCE_RESET;
            irq_mask <= '0;
        end else begin
            if (wr_chain_addr) begin
                chain_addr <= wr_data[7:0];
            end
            if (wr_chain_ctrl) begin
                head_flag <= wr_data[CTRL_HEAD_BIT];
                tail_flag <= wr_data[CTRL_TAIL_BIT];
            end
            if (wr_control) begin
                auto_advance_enable <= wr_data[CONTROL_ADVANCE_BIT];
            end
            if (wr_irq_mask) begin
                irq_mask <= wr_data[IRQ_WIDTH-1:0];
            end
        end
    end

    // Drained persists until i_vme_berr_seen or chain_done clears it; a set in the same cycle wins over the clear.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drained <= 1'b0;
        end else if (set_drained) begin
            drained <= 1'b1;
        end else if (i_vme_berr_seen || chain_done) begin
            drained <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status <= '0;
            o_irq <= 1'b0;
            o_reg_rdata <= 32'h00000000;
        end else begin
            irq_status <= next_irq_status;
            o_irq <= |(next_irq_status & irq_mask);
            o_reg_rdata <= i_reg_rd ? next_reg_rdata : 32'h00000000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_vme_dtack <= 1'b0;
            o_vme_berr <= 1'b0;
            o_vme_rdata <= 64'h0000000000000000;
            o_iack_out <= 1'b0;
            o_evt_ready <= 1'b0;
        end else begin
            o_vme_dtack <= data_beat || addr_ack || mcast_write;
            o_vme_berr <= chain_done;
            o_vme_rdata <= data_beat ? {32'h00000000, trailer_word} : 64'h0000000000000000;
            o_iack_out <= token && (set_drained || spent) && !is_tail;
            o_evt_ready <= store_ready;
        end
    end
endmodule // chain_readout

// File: hdl/event_store.sv
/*
 * Circular word store for complete events. Words become visible to the
 * reader only once the trailer of their event has been written, so a board
 * never starts sending a half-built event.
 * Assumes the writer stops while o_full is high.
 */
`timescale 1ns/1ns
module event_store
    import chain_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH_LOG = 11
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_word,
    output logic o_wr_ready,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_word,
    output logic o_empty,
    output logic o_full
);
    logic [WIDTH-1:0] mem [0:(1<<DEPTH_LOG)-1];
    logic [DEPTH_LOG:0] wr_ptr;
    logic [DEPTH_LOG:0] commit_ptr;
    logic [DEPTH_LOG:0] rd_ptr;
    wire wr_fire = i_wr_valid && o_wr_ready;
    wire wr_is_trailer = i_wr_word[TYPE_MSB:TYPE_LSB] == TYPE_TRAILER;
    wire [DEPTH_LOG:0] next_wr_ptr = wr_ptr + 1'b1;

    assign o_full = (wr_ptr[DEPTH_LOG] != rd_ptr[DEPTH_LOG]) &&
                    (wr_ptr[DEPTH_LOG-1:0] == rd_ptr[DEPTH_LOG-1:0]);
    assign o_wr_ready = !o_full;
    assign o_empty = commit_ptr == rd_ptr;
    assign o_word = mem[rd_ptr[DEPTH_LOG-1:0]];

    always_ff @(posedge i_clk) begin
        if (wr_fire) begin
            mem[wr_ptr[DEPTH_LOG-1:0]] <= i_wr_word;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            commit_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (wr_fire) begin
                wr_ptr <= next_wr_ptr;
            end
            if (wr_fire && wr_is_trailer) begin
                commit_ptr <= next_wr_ptr;
            end
            if (i_pop && !o_empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // event_store
